// [logic/rsq_pkg.sv]
// Package with register map, field layout and strobe codes for rail sequencing.
package rsq_pkg;
   localparam logic [7:0] ADDR_ENABLE   = 8'h16;
   localparam logic [7:0] ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL     = 8'h18;
   localparam logic [7:0] ADDR_SLOT_A   = 8'h19;
   localparam logic [7:0] ADDR_SLOT_B   = 8'h1A;
   localparam logic [7:0] ADDR_SLOT_C   = 8'h1B;
   localparam logic [7:0] ADDR_STROBE   = 8'h1F;
   localparam logic [7:0] RST_ENABLE    = 8'h00;
   localparam logic [7:0] RST_UNDERVOLTAGE_LOCKOUT_LEVEL      = 8'h00;
   localparam logic [7:0] RST_SLOT      = 8'h00;
   localparam logic [7:0] MASK_ENABLE   = 8'h7F;
   localparam logic [7:0] MASK_UNDERVOLTAGE_LOCKOUT_LEVEL     = 8'h07;
   localparam logic [7:0] MASK_SLOT     = 8'h77;
   localparam logic [7:0] MASK_SLOT_B   = 8'h7F;
   localparam int         RAILS         = 7;
   localparam int         BIT_SW1       = 6;
   localparam int         BIT_SW2       = 5;
   localparam int         BIT_BUCK1     = 4;
   localparam int         BIT_BUCK2     = 3;
   localparam int         BIT_BUCK3     = 2;
   localparam int         BIT_REG1      = 1;
   localparam int         BIT_REG2      = 0;
   localparam logic [3:0] STROBE_NONE   = 4'h0;
   localparam logic [3:0] STROBE_SIX    = 4'h6;
   localparam logic [3:0] STROBE_MAXLO  = 4'h7;
   localparam logic [3:0] STROBE_14     = 4'hE;
   localparam logic [3:0] STROBE_15     = 4'hF;
   localparam logic [3:0] CODE_LO_NONE  = 4'h8;
   localparam logic [3:0] CODE_HI_NONE  = 4'h9;
   localparam logic [7:0] RD_ZERO       = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rsq_req_t;

   typedef struct packed {
      logic [6:0] rail_on;
      logic [1:0] undervoltage_lockout_level_level;
   } rsq_out_t;
endpackage : rsq_pkg

// [logic/rsq_rail_seq.sv]
// Rail enable register bank, lockout selector and strobe slot decoding.
//
// Function
// - Enable bit 6 switches load switch one.
// - Load switch one turns on only while the power enable pin is high.
// - Enable bit 5 switches load switch two, also gated by power enable.
// - Enable bits 4,3,2 switch bucks one to three, gated by power enable.
// - Enable bits 1 and 0 switch regulators one and two.
// - Reserved bits read zero and ignore writes.
// - Three-bit lockout field, low two bits select threshold, resets to zero.
// - Buck one and two slot codes 000 none, 001 to 110 strobes one-six.
// - Buck one and two code 111 is taken as strobe six.
// - Buck three slot code 000 none, 001 to 111 strobes one-seven.
// - Regulator one codes 0000,1000,1001 unsequenced; 0001-0111 strobes 1-7.
// - Regulator one codes 1010-1101 reserved; 1110 is strobe fourteen.
// - Regulator one code 1111 is strobe fifteen, with system supply.
// - Lockout and slot registers accept writes only when unlocked.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module rsq_rail_seq (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   input  wire rsq_pkg::rsq_req_t i_req,
   input  wire logic              i_power_enable_pin,
   input  wire logic              i_unlocked,
   input  wire logic [3:0]        i_active_strobe,
   output logic [7:0]             o_rdata,
   output rsq_pkg::rsq_out_t      o_rails,
   output logic [3:0]             o_buck_one_slot,
   output logic [3:0]             o_buck_two_slot,
   output logic [3:0]             o_buck_three_slot,
   output logic [3:0]             o_regulator_one_slot
);
   import rsq_pkg::*;

   logic [7:0] enable_q,  enable_d;
   logic [7:0] undervoltage_lockout_level_q,    undervoltage_lockout_level_d;
   logic [7:0] slot_a_q,  slot_a_d;
   logic [7:0] slot_b_q,  slot_b_d;
   logic [7:0] rdata_q,   rdata_d;
   logic [2:0] pin_sync_q, pin_sync_d;
   logic       pin_on_q,  pin_on_d;
   logic [6:0] rail_q,    rail_d;
   logic [3:0] slot_buck1, slot_buck2, slot_buck3, slot_reg1;
   logic [6:0] seq_hit;
   logic [6:0] seq_ctl;

   // Register writes and read mux.
   always_comb begin
      enable_d = enable_q;
      undervoltage_lockout_level_d   = undervoltage_lockout_level_q;
      slot_a_d = slot_a_q;
      slot_b_d = slot_b_q;
      rdata_d  = RD_ZERO;
      if (i_req.wr) begin
         case (i_req.addr)
            ADDR_ENABLE: enable_d = i_req.wdata & MASK_ENABLE;
            ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL: begin
               if (i_unlocked) begin
                  undervoltage_lockout_level_d = i_req.wdata & MASK_UNDERVOLTAGE_LOCKOUT_LEVEL;
               end
            end
            ADDR_SLOT_A: begin
               if (i_unlocked) begin
                  slot_a_d = i_req.wdata & MASK_SLOT;
               end
            end
            ADDR_SLOT_B: begin
               if (i_unlocked) begin
                  // The regulator-one field is four bits wide, down to bit 0.
                  slot_b_d = i_req.wdata & MASK_SLOT_B;
               end
            end
            default: begin
            end
         endcase
      end
      if (i_req.rd) begin
         case (i_req.addr)
            ADDR_ENABLE: rdata_d = enable_q;
            ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL:   rdata_d = undervoltage_lockout_level_q;
            ADDR_SLOT_A: rdata_d = slot_a_q;
            ADDR_SLOT_B: rdata_d = slot_b_q;
            ADDR_STROBE: rdata_d = {1'b0, rail_q};
            default:     rdata_d = RD_ZERO;
         endcase
      end
   end

   // Slot fields decoded to strobe numbers; zero means unsequenced.
   always_comb begin
      slot_buck1 = {1'b0, slot_a_q[6:4]};
      if (slot_buck1 == STROBE_MAXLO) begin
         // Duplicate code kept as strobe six so both codes behave alike.
         slot_buck1 = STROBE_SIX;
      end
      slot_buck2 = {1'b0, slot_a_q[2:0]};
      if (slot_buck2 == STROBE_MAXLO) begin
         slot_buck2 = STROBE_SIX;
      end
      slot_buck3 = {1'b0, slot_b_q[6:4]};
      case (slot_b_q[3:0])
         CODE_LO_NONE, CODE_HI_NONE: slot_reg1 = STROBE_NONE;
         STROBE_14: slot_reg1 = STROBE_14;
         STROBE_15: slot_reg1 = STROBE_15;
         default: begin
            if (slot_b_q[3:0] <= STROBE_MAXLO) begin
               slot_reg1 = slot_b_q[3:0];
            end else begin
               // Reserved codes leave the rail out of the sequence.
               slot_reg1 = STROBE_NONE;
            end
         end
      endcase
   end

   // Per-rail sequencer reach; switches and regulator two have no slot here.
   always_comb begin
      seq_ctl = '0;
      seq_hit = '0;
      seq_ctl[BIT_BUCK1] = (slot_buck1 != STROBE_NONE);
      seq_ctl[BIT_BUCK2] = (slot_buck2 != STROBE_NONE);
      seq_ctl[BIT_BUCK3] = (slot_buck3 != STROBE_NONE);
      seq_ctl[BIT_REG1]  = (slot_reg1 != STROBE_NONE);
      seq_hit[BIT_BUCK1] = seq_ctl[BIT_BUCK1]
                           && (i_active_strobe >= slot_buck1);
      seq_hit[BIT_BUCK2] = seq_ctl[BIT_BUCK2]
                           && (i_active_strobe >= slot_buck2);
      seq_hit[BIT_BUCK3] = seq_ctl[BIT_BUCK3]
                           && (i_active_strobe >= slot_buck3);
      seq_hit[BIT_REG1]  = seq_ctl[BIT_REG1]
                           && (i_active_strobe >= slot_reg1);
   end

   // The pin is asynchronous; a change counts once stages two and three agree.
   always_comb begin
      pin_sync_d = {pin_sync_q[1:0], i_power_enable_pin};
      pin_on_d   = pin_on_q;
      if (pin_sync_q[2] == pin_sync_q[1]) begin
         pin_on_d = pin_sync_q[2];
      end
   end

   // Rail outputs; the pin gates the three switchable groups.
   always_comb begin
      rail_d = '0;
      for (int i = 0; i < RAILS; i++) begin
         // Unsequenced rails respond to their enable bit alone.
         rail_d[i] = enable_q[i] | seq_hit[i];
      end
      rail_d[BIT_SW1] = enable_q[BIT_SW1] & pin_on_q;
      rail_d[BIT_SW2] = enable_q[BIT_SW2] & pin_on_q;
      rail_d[BIT_BUCK1] = (enable_q[BIT_BUCK1] | seq_hit[BIT_BUCK1])
                          & pin_on_q;
      rail_d[BIT_BUCK2] = (enable_q[BIT_BUCK2] | seq_hit[BIT_BUCK2])
                          & pin_on_q;
      rail_d[BIT_BUCK3] = (enable_q[BIT_BUCK3] | seq_hit[BIT_BUCK3])
                          & pin_on_q;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         enable_q   <= RST_ENABLE;
         undervoltage_lockout_level_q     <= RST_UNDERVOLTAGE_LOCKOUT_LEVEL;
         slot_a_q   <= RST_SLOT;
         slot_b_q   <= RST_SLOT;
         rdata_q    <= RD_ZERO;
         pin_sync_q <= '0;
         pin_on_q   <= 1'b0;
         rail_q     <= '0;
      end else begin
         enable_q   <= enable_d;
         undervoltage_lockout_level_q     <= undervoltage_lockout_level_d;
         slot_a_q   <= slot_a_d;
         slot_b_q   <= slot_b_d;
         rdata_q    <= rdata_d;
         pin_sync_q <= pin_sync_d;
         pin_on_q   <= pin_on_d;
         rail_q     <= rail_d;
      end
   end

   assign o_rdata               = rdata_q;
   assign o_rails.rail_on       = rail_q;
   assign o_rails.undervoltage_lockout_level_level    = undervoltage_lockout_level_q[1:0];
   assign o_buck_one_slot       = slot_buck1;
   assign o_buck_two_slot       = slot_buck2;
   assign o_buck_three_slot     = slot_buck3;
   assign o_regulator_one_slot  = slot_reg1;
endmodule : rsq_rail_seq

// [bench/rsq_rail_seq_checker.sv]
// Port assertions for the rail sequencing register bank.
`timescale 1ns/1ps
module rsq_rail_seq_checker (
   input wire logic              i_clk_sys,
   input wire logic              i_rst_n,
   input wire rsq_pkg::rsq_req_t i_req,
   input wire logic              i_power_enable_pin,
   input wire logic              i_unlocked,
   input wire logic [3:0]        i_active_strobe,
   input wire logic [7:0]        o_rdata,
   input wire rsq_pkg::rsq_out_t o_rails,
   input wire logic [3:0]        o_buck_one_slot,
   input wire logic [3:0]        o_buck_two_slot,
   input wire logic [3:0]        o_buck_three_slot,
   input wire logic [3:0]        o_regulator_one_slot
);
   import rsq_pkg::*;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   property p_rd_idle;
      !$past(i_req.rd) |-> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   // Seven samples cover the pin filter plus the output register.
   property p_pin_gate;
      !i_power_enable_pin [*7] |-> o_rails.rail_on[6:2] == 5'h00;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("rail on, pin low");
   property p_rsv_enable;
      $past(i_req.rd) && $past(i_req.addr) == ADDR_ENABLE |-> !o_rdata[7];
   endproperty
   a_rsv_enable: assert property (p_rsv_enable) else $error("bit 7 set");
   property p_rsv_undervoltage_lockout_level;
      $past(i_req.rd) && $past(i_req.addr) == ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL
         |-> o_rdata[7:3] == 5'h00;
   endproperty
   a_rsv_undervoltage_lockout_level: assert property (p_rsv_undervoltage_lockout_level) else $error("bits 7:3 set");
   property p_lock;
      i_req.wr && i_req.addr == ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL && !i_unlocked && !$past(i_req.wr)
         |=> $stable(o_rails.undervoltage_lockout_level_level) [*2];
   endproperty
   a_lock: assert property (p_lock) else $error("locked write taken");
   property p_buck_one;
      i_req.wr && i_req.addr == ADDR_SLOT_A && i_unlocked
         |=> o_buck_one_slot == (($past(i_req.wdata[6:4]) == 3'h7) ? 4'h6
            : {1'b0, $past(i_req.wdata[6:4])});
   endproperty
   a_buck_one: assert property (p_buck_one) else $error("buck one slot");
   property p_buck_three;
      i_req.wr && i_req.addr == ADDR_SLOT_B && i_unlocked
         |=> o_buck_three_slot == {1'b0, $past(i_req.wdata[6:4])};
   endproperty
   a_buck_three: assert property (p_buck_three) else $error("buck 3 slot");
   property p_reg_none;
      i_req.wr && i_req.addr == ADDR_SLOT_B && i_unlocked
         && i_req.wdata[3:0] inside {4'h0, [4'h8:4'hD]}
         |=> o_regulator_one_slot == 4'h0;
   endproperty
   a_reg_none: assert property (p_reg_none) else $error("reg one slot");
endmodule : rsq_rail_seq_checker

// [bench/test_rsq_rail_seq.sv]
// Self-checking bench for the rail sequencing register bank.
`timescale 1ns/1ps
module test_rsq_rail_seq;
   import rsq_pkg::*;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } rsq_row_t;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   rsq_req_t   req = '0;
   logic       pin = 1'b0;
   logic       unlocked = 1'b1;
   logic [3:0] strobe = 4'h0;
   logic [7:0] rdata;
   rsq_out_t   rails;
   logic [3:0] s_b1, s_b2, s_b3, s_r1, e1, er;
   logic [7:0] got;
   int         n_fail = 0;
   int         checked = 0;
   rsq_row_t   rows [9] = '{'{ADDR_ENABLE, 8'hFF, 8'h7F},
      '{ADDR_ENABLE, 8'h00, 8'h00}, '{ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL, 8'hF8, 8'h00},
      '{ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL, 8'hF9, 8'h01}, '{ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL, 8'hFA, 8'h02},
      '{ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL, 8'hFB, 8'h03}, '{ADDR_SLOT_A, 8'hFF, 8'h77},
      '{ADDR_SLOT_B, 8'hFF, 8'h7F}, '{8'h10, 8'hFF, 8'h00}};
   always #10 clk_sys = ~clk_sys;
   rsq_rail_seq rsq_rail_seq_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
      .i_req(req), .i_power_enable_pin(pin), .i_unlocked(unlocked),
      .i_active_strobe(strobe), .o_rdata(rdata), .o_rails(rails),
      .o_buck_one_slot(s_b1), .o_buck_two_slot(s_b2),
      .o_buck_three_slot(s_b3), .o_regulator_one_slot(s_r1));
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req <= '0;
      #1 got = rdata;
   endtask : rd
   task automatic give_verdict();
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i].addr);
         cmp(got, 8'h00);
      end
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr);
         cmp(got, rows[i].exp);
         if (rows[i].addr == ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL) begin
            cmp({6'h00, rails.undervoltage_lockout_level_level}, {6'h00, rows[i].wdata[1:0]});
         end
      end
      // A locked write must leave the last unlocked value in place.
      unlocked <= 1'b0;
      wr(ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL, 8'h02);
      rd(ADDR_UNDERVOLTAGE_LOCKOUT_LEVEL);
      cmp(got, 8'h03);
      unlocked <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_SLOT_A, {1'b0, c[2:0], 1'b0, c[2:0]});
         wr(ADDR_SLOT_B, {1'b0, c[2:0], c[3:0]});
         #1;
         e1 = (c[2:0] == 3'h7) ? 4'h6 : {1'b0, c[2:0]};
         er = (c[3:0] inside {4'h0, [4'h8:4'hD]}) ? 4'h0 : c[3:0];
         cmp({4'h0, s_b1}, {4'h0, e1});
         cmp({4'h0, s_b2}, {4'h0, e1});
         cmp({4'h0, s_b3}, {5'h00, c[2:0]});
         cmp({4'h0, s_r1}, {4'h0, er});
      end
      wr(ADDR_SLOT_A, 8'h00);
      wr(ADDR_SLOT_B, 8'h00);
      strobe <= 4'hF;
      pin <= 1'b1;
      for (int k = 0; k < RAILS; k++) begin
         wr(ADDR_ENABLE, 8'h01 << k);
         repeat (6) @(posedge clk_sys);
         #1;
         cmp({1'b0, rails.rail_on}, 8'h01 << k);
      end
      // Buck one on slot three must wait for strobe three.
      wr(ADDR_ENABLE, 8'h00);
      wr(ADDR_SLOT_A, 8'h30);
      strobe <= 4'h2;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp({1'b0, rails.rail_on}, 8'h00);
      strobe <= 4'h3;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp({1'b0, rails.rail_on}, 8'h10);
      wr(ADDR_SLOT_A, 8'h00);
      wr(ADDR_ENABLE, 8'h7F);
      pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      cmp({1'b0, rails.rail_on}, 8'h03);
      give_verdict();
   end
endmodule : test_rsq_rail_seq
bind rsq_rail_seq rsq_rail_seq_checker rsq_rail_seq_checker_i (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req),
   .i_power_enable_pin(i_power_enable_pin), .i_unlocked(i_unlocked),
   .i_active_strobe(i_active_strobe), .o_rdata(o_rdata), .o_rails(o_rails),
   .o_buck_one_slot(o_buck_one_slot), .o_buck_two_slot(o_buck_two_slot),
   .o_buck_three_slot(o_buck_three_slot),
   .o_regulator_one_slot(o_regulator_one_slot));
